// ---- design/rts_sequencer.sv ----
// Reset time-out sequencer: power-up delay, oscillator start-up count, status register.
`timescale 1ns/1ps
`default_nettype none
module rts_sequencer
    import rts_pkg::*;
#(
    parameter int unsigned DELAY_COUNT     = DELAY_CYCLES,
    parameter int unsigned STARTUP_COUNT   = STARTUP_PERIODS,
    parameter int unsigned BROWNOUT_FILTER = BROWNOUT_MIN_CYCLES,
    parameter int unsigned PIN_FILTER      = PIN_FILTER_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic        poweron_pulse,
    input  wire logic        brownout_detect,
    input  wire logic        external_reset_pin_n,
    input  wire logic        oscillator_input,
    input  wire logic        powerup_timer_tick,
    input  wire logic        sleep_wakeup,
    input  wire logic        watchdog_reset,
    input  wire rts_config_t cfg,
    input  wire rts_flags_t  wdt_flags,
    input  wire logic        reg_addr,
    input  wire logic [1:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [3:0]       reg_rdata,
    output logic             internal_reset,
    output logic [1:0]       reset_cause,
    output logic             brownout_flag_n,
    output logic             poweron_flag_n,
    output logic             powerup_timer_active,
    output logic             osc_startup_active
);

    // Sequence overview. A power-on pulse or a qualified brown-out parks the
    // sequencer in the hold state. When the pulse has ended and the supply
    // is good, the power-up delay runs on ticks of its own slow clock unless
    // the disable bit skips it on a power-up, then in the crystal modes the
    // start-up count waits for the crystal to settle, and only then is
    // the run state entered. The pin and the watchdog hold the reset output
    // but never touch the sequence, so the time-outs can expire beneath a
    // low pin and execution starts as soon as the pin is released.
    //
    // Limitation: the delay length is a count of timer ticks, not a time;
    // its accuracy is that of the tick source, which lies outside.

    // A count of zero would make the end-of-count compare match at once and
    // silently skip that time-out, so such a build is refused outright.
    if (DELAY_COUNT < 1 || STARTUP_COUNT < 1 || BROWNOUT_FILTER < 1 || PIN_FILTER < 1) begin
        $error("rts_sequencer: counts must be at least one");
    end

    // Counter widths leave room for the terminal count itself.
    localparam int PW = $clog2(DELAY_COUNT + 1);
    localparam int OW = $clog2(STARTUP_COUNT + 1);
    localparam int BW = $clog2(BROWNOUT_FILTER + 1);
    localparam int FW = $clog2(PIN_FILTER + 1);

    // Only resistor-capacitor mode runs without a crystal; the other three
    // modes need the start-up count after power-on and wake-up.
    function automatic logic is_crystal(input logic [1:0] mode);
        return mode != OSC_RC;
    endfunction

    // Bits that the watchdog owns read as set while the power-on flag is
    // still clear, since a power-on always sets both of them.
    function automatic logic flag_view(input logic wdt_bit, input logic por_flag_n);
        return wdt_bit | ~por_flag_n;
    endfunction

    // Only one address is decoded; writes elsewhere are dropped and reads
    // elsewhere return zero.
    function automatic logic hits_status(input logic addr);
        return addr == REG_ADDR_STATUS;
    endfunction

    rts_state_t      state;
    rts_state_t      next_state;
    logic [PW-1:0]   delay_cnt;
    logic [OW-1:0]   startup_cnt;
    logic [BW-1:0]   brownout_cnt;
    logic [FW-1:0]   pin_cnt;
    logic            brownout_active;
    logic            brownout_seen;
    logic            pin_low;
    logic            osc_prev;
    logic            osc_rise;
    logic            wake_pending;
    logic            next_reset;

    ////////////////////////////////////////////////////////////////////////////
    // Reset pin noise filter and brown-out qualification.

    // The pin must hold its new level for the whole filter window before the
    // filtered value follows, so brief spikes never reach the reset tree.
    // A pin that bounces inside the window restarts the wait each time, so a
    // noisy release costs a little extra reset time rather than a false run.
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_cnt <= '0;
            pin_low <= 1'b0;
        end else if (clk_en) begin
            if ((~external_reset_pin_n) == pin_low) begin
                pin_cnt <= '0;
            end else if (pin_cnt == FW'(PIN_FILTER - 1)) begin
                pin_cnt <= '0;
                pin_low <= ~external_reset_pin_n;
            end else begin
                pin_cnt <= pin_cnt + 1'b1;
            end
        end
    end

    // A brown-out must last the full qualification window before it counts;
    // shorter dips are treated as supply noise. The flag drops as soon as the
    // supply recovers, and the delay timer then takes over the hold.
    always_ff @(posedge mclk) begin
        if (rst) begin
            brownout_cnt    <= '0;
            brownout_active <= 1'b0;
        end else if (clk_en) begin
            if (!cfg.brownout_enable || !brownout_detect) begin
                brownout_cnt    <= '0;
                brownout_active <= 1'b0;
            end else if (brownout_cnt == BW'(BROWNOUT_FILTER - 1)) begin
                brownout_active <= 1'b1;
            end else begin
                brownout_cnt <= brownout_cnt + 1'b1;
            end
        end
    end

    // A brown-out that has been seen is remembered until the run state is
    // reached again or a power-on pulse arrives, so that the hold state knows to run the delay.
    always_ff @(posedge mclk) begin
        if (rst) begin
            brownout_seen <= 1'b0;
        end else if (clk_en) begin
            if (brownout_active) begin
                brownout_seen <= 1'b1;
            end else if (state == RTS_RUN || poweron_pulse) begin
                brownout_seen <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Time-out sequence.

    // The oscillator input is treated as synchronous; one rising edge is one
    // period, so it must run at no more than half the sequencer clock.
    always_ff @(posedge mclk) begin
        if (rst) begin
            osc_prev <= 1'b0;
        end else if (clk_en) begin
            osc_prev <= oscillator_input;
        end
    end
    assign osc_rise = oscillator_input & ~osc_prev;

    // A wake-up only needs the oscillator start-up count, never the delay.
    // In resistor-capacitor mode a wake-up runs no time-out at all.
    always_ff @(posedge mclk) begin
        if (rst) begin
            wake_pending <= 1'b0;
        end else if (clk_en) begin
            if (state == RTS_RUN && sleep_wakeup && is_crystal(cfg.osc_mode)) begin
                wake_pending <= 1'b1;
            end else if (state == RTS_STARTUP) begin
                wake_pending <= 1'b0;
            end
        end
    end

    // A power-on pulse wins over everything and restarts from the hold
    // state. Leaving hold after a brown-out always runs the delay, whatever
    // the disable bit says; the disable bit and the resistor-capacitor
    // shortcut only shape a genuine power-up.
    always_comb begin
        next_state = state;
        unique case (state)
            RTS_HOLD: begin
                if (!poweron_pulse && !brownout_active) begin
                    if (brownout_seen) begin
                        next_state = RTS_DELAY;
                    end else if (!cfg.powerup_timer_disable_n) begin
                        next_state = RTS_DELAY;
                    end else if (is_crystal(cfg.osc_mode)) begin
                        next_state = RTS_STARTUP;
                    end else begin
                        next_state = RTS_RUN;
                    end
                end
            end
            RTS_DELAY: begin
                if (brownout_active) begin
                    next_state = RTS_HOLD;
                end else if (delay_cnt == PW'(DELAY_COUNT)) begin
                    next_state = is_crystal(cfg.osc_mode) ? RTS_STARTUP : RTS_RUN;
                end
            end
            RTS_STARTUP: begin
                if (brownout_active) begin
                    next_state = RTS_HOLD;
                end else if (startup_cnt == OW'(STARTUP_COUNT)) begin
                    next_state = RTS_RUN;
                end
            end
            RTS_RUN: begin
                if (poweron_pulse || brownout_active) begin
                    next_state = RTS_HOLD;
                end else if (wake_pending) begin
                    next_state = RTS_STARTUP;
                end
            end
        endcase
        if (poweron_pulse) begin
            next_state = RTS_HOLD;
        end
    end

    // The state register is frozen with everything else while the clock
    // enable is low, so a stalled clock never shortens a time-out.
    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= RTS_HOLD;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // The delay timer counts ticks of its own RC clock, independent of the pin.
    // It is cleared whenever it is not running, so a brown-out during the
    // delay always restarts it from zero rather than resuming.
    always_ff @(posedge mclk) begin
        if (rst) begin
            delay_cnt <= '0;
        end else if (clk_en) begin
            if (state != RTS_DELAY || brownout_active) begin
                delay_cnt <= '0;
            end else if (powerup_timer_tick && delay_cnt != PW'(DELAY_COUNT)) begin
                delay_cnt <= delay_cnt + 1'b1;
            end
        end
    end

    // The start-up count saturates at its terminal value; the state change
    // is decided from that value, one cycle after the last edge arrives.
    always_ff @(posedge mclk) begin
        if (rst) begin
            startup_cnt <= '0;
        end else if (clk_en) begin
            if (state != RTS_STARTUP) begin
                startup_cnt <= '0;
            end else if (osc_rise && startup_cnt != OW'(STARTUP_COUNT)) begin
                startup_cnt <= startup_cnt + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Internal reset and cause report.

    // The reset follows the next state, so it rises on the very edge at which
    // a wake-up enters the start-up count and falls on the edge at which the
    // run state is entered. A watchdog reset or a low pin holds the reset
    // but leaves the sequence alone: the time-outs run on regardless.
    assign next_reset = poweron_pulse | brownout_active | pin_low | watchdog_reset
                      | (next_state != RTS_RUN);

    always_ff @(posedge mclk) begin
        if (rst) begin
            internal_reset       <= 1'b1;
            powerup_timer_active <= 1'b0;
            osc_startup_active   <= 1'b0;
        end else if (clk_en) begin
            internal_reset       <= next_reset;
            powerup_timer_active <= (next_state == RTS_DELAY);
            osc_startup_active   <= (next_state == RTS_STARTUP);
        end
    end

    // Priority follows severity: a power-on outranks a brown-out, and both
    // outrank the pin and the watchdog. The cause returns to none only once
    // the reset has actually been released.
    always_ff @(posedge mclk) begin
        if (rst) begin
            reset_cause <= RTS_CAUSE_NONE;
        end else if (clk_en) begin
            if (poweron_pulse) begin
                reset_cause <= RTS_CAUSE_POWERON;
            end else if (brownout_active) begin
                reset_cause <= RTS_CAUSE_BROWNOUT;
            end else if (pin_low || watchdog_reset) begin
                reset_cause <= RTS_CAUSE_OTHER;
            end else if (!next_reset) begin
                reset_cause <= RTS_CAUSE_NONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power status register. Hardware clears beat software sets in one cycle.

    // Both flags are active low; hardware or a software write clears them. The reset
    // value stands for the undefined value after power-on; software is
    // expected to write both bits to one once it has read the cause.
    always_ff @(posedge mclk) begin
        if (rst) begin
            brownout_flag_n <= STATUS_RESET[BIT_BROWNOUT];
            poweron_flag_n  <= STATUS_RESET[BIT_POWERON];
        end else if (clk_en) begin
            if (brownout_active) begin
                brownout_flag_n <= 1'b0;
            end else if (reg_wr && hits_status(reg_addr)) begin
                brownout_flag_n <= reg_wdata[BIT_BROWNOUT];
            end
            if (poweron_pulse) begin
                poweron_flag_n <= 1'b0;
            end else if (reg_wr && hits_status(reg_addr)) begin
                poweron_flag_n <= reg_wdata[BIT_POWERON];
            end
        end
    end

    // Read word: power status in bits 1:0, watchdog-owned flags in bits 3:2,
    // so one read decodes the cause. Watchdog flags are forced set while the power-on flag is clear.
    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (clk_en) begin
            if (reg_rd && hits_status(reg_addr)) begin
                reg_rdata <= {
                    flag_view(wdt_flags.timeout_flag_n, poweron_flag_n),
                    flag_view(wdt_flags.powerdown_flag_n, poweron_flag_n),
                    poweron_flag_n,
                    brownout_flag_n
                };
            end else begin
                reg_rdata <= '0;
            end
        end
    end

endmodule
`default_nettype wire

// ---- design/rts_pkg.sv ----
// Package for the reset time-out sequencer: constants, modes, states and carriers.
package rts_pkg;

    localparam int unsigned CLK_HZ             = 50_000_000;
    localparam int unsigned DELAY_MS           = 72;
    localparam int unsigned DELAY_CYCLES       = (CLK_HZ / 1000) * DELAY_MS;
    localparam int unsigned STARTUP_PERIODS    = 1024;
    localparam int unsigned BROWNOUT_MIN_CYCLES = 4;
    localparam int unsigned PIN_FILTER_CYCLES  = 4;

    localparam logic [1:0] OSC_LOW_POWER       = 2'h0;
    localparam logic [1:0] OSC_STANDARD        = 2'h1;
    localparam logic [1:0] OSC_HIGH_SPEED      = 2'h2;
    localparam logic [1:0] OSC_RC              = 2'h3;

    localparam int unsigned BIT_BROWNOUT       = 0;
    localparam int unsigned BIT_POWERON        = 1;
    localparam logic [1:0]  STATUS_RESET       = 2'h0;
    localparam logic        REG_ADDR_STATUS    = 1'h0;

    typedef enum logic [3:0] {
        RTS_HOLD    = 4'h1,
        RTS_DELAY   = 4'h2,
        RTS_STARTUP = 4'h4,
        RTS_RUN     = 4'h8
    } rts_state_t;

    typedef enum logic [1:0] {
        RTS_CAUSE_NONE     = 2'h0,
        RTS_CAUSE_POWERON  = 2'h1,
        RTS_CAUSE_BROWNOUT = 2'h2,
        RTS_CAUSE_OTHER    = 2'h3
    } rts_cause_t;

    typedef struct packed {
        logic [1:0] osc_mode;
        logic       powerup_timer_disable_n;
        logic       brownout_enable;
    } rts_config_t;

    typedef struct packed {
        logic       timeout_flag_n;
        logic       powerdown_flag_n;
    } rts_flags_t;

endpackage

// ---- test/rts_checker.sv ----
// Concurrent assertions on the ports of the reset time-out sequencer.
`timescale 1ns/1ps
`default_nettype none
module rts_checker
    import rts_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        clk_en,
    input wire logic        poweron_pulse,
    input wire logic        brownout_detect,
    input wire logic        external_reset_pin_n,
    input wire rts_config_t cfg,
    input wire logic        reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [3:0]  reg_rdata,
    input wire logic        internal_reset,
    input wire logic        brownout_flag_n,
    input wire logic        poweron_flag_n,
    input wire logic        powerup_timer_active,
    input wire logic        osc_startup_active
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    sequence rd_taken;
        clk_en && reg_rd && !reg_addr;
    endsequence
    sequence pin_held;
        (clk_en && !external_reset_pin_n)[*8];
    endsequence
    AST_RD_IDLE: assert property (clk_en && !(reg_rd && !reg_addr) |=> reg_rdata == 4'h0)
        else $error("read data not zero outside a read");
    AST_RD_DATA: assert property (rd_taken ##1 ($stable(poweron_flag_n) && $stable(brownout_flag_n))
        |-> reg_rdata[1:0] == {poweron_flag_n, brownout_flag_n})
        else $error("read data differs from the status bits");
    AST_POR_FLAG: assert property ($fell(poweron_flag_n) && !$past(reg_wr)
        |-> $past(poweron_pulse) || $past(poweron_pulse, 2) || $past(poweron_pulse, 3))
        else $error("power-on flag cleared without a power-on pulse");
    AST_BROWNOUT_FLAG: assert property ($fell(brownout_flag_n) && !$past(reg_wr)
        |-> cfg.brownout_enable && ($past(brownout_detect) || $past(brownout_detect, 2)))
        else $error("brown-out flag cleared without an enabled brown-out");
    AST_DELAY_HOLD: assert property (powerup_timer_active |-> internal_reset)
        else $error("delay timer running outside reset");
    AST_STARTUP_HOLD: assert property (osc_startup_active |-> internal_reset)
        else $error("start-up count running outside reset");
    AST_PIN_RESET: assert property (pin_held |-> internal_reset)
        else $error("long low pin gave no reset");
    AST_STARTUP_ORDER: assert property ($rose(osc_startup_active)
        |-> !powerup_timer_active && !poweron_pulse)
        else $error("start-up count began before the delay ended");
    AST_RC_NO_STARTUP: assert property (cfg.osc_mode == OSC_RC |-> !$rose(osc_startup_active))
        else $error("start-up count in RC mode");
    AST_DELAY_LEN: assert property ($rose(powerup_timer_active) |-> powerup_timer_active[*8])
        else $error("delay timer ended early");
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench for the reset time-out sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import rts_pkg::*;
;
    localparam int PW = 8;
    localparam int TK = 8;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        clk_en = 1'b1;
    logic        poweron_pulse = 1'b1;
    logic        brownout_detect = 1'b0;
    logic        external_reset_pin_n = 1'b1;
    logic        oscillator_input = 1'b0;
    logic        powerup_timer_tick = 1'b0;
    logic        sleep_wakeup = 1'b0;
    logic        watchdog_reset = 1'b0;
    rts_config_t cfg = '{OSC_STANDARD, 1'b0, 1'b1};
    rts_flags_t  wdt_flags = 2'h2;
    logic        reg_addr = 1'b0;
    logic [1:0]  reg_wdata = 2'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [3:0]  reg_rdata;
    logic        internal_reset;
    logic [1:0]  reset_cause;
    logic        brownout_flag_n;
    logic        poweron_flag_n;
    logic        powerup_timer_active;
    logic        osc_startup_active;
    logic [2:0]  tick_phase = 3'h0;
    logic [3:0]  d;
    logic [1:0]  v;
    int          n_fail = 0;
    int          total_checks = 0;
    int          por_n = 0;
    int          bor_n = 0;
    int          pw;
    int          os;
    ////////////////////////////////////////////////////////////////////////////////
    always #10 mclk = ~mclk;
    // Sparse ticks make a tick count of one too few show as a whole tick period.
    always @(posedge mclk) begin
        oscillator_input <= ~oscillator_input;
        tick_phase <= tick_phase + 3'h1;
        powerup_timer_tick <= (tick_phase == 3'h0);
    end
    rts_sequencer #(.DELAY_COUNT(PW)) i_rts_sequencer (
        .mclk(mclk), .rst(rst), .clk_en(clk_en), .poweron_pulse(poweron_pulse),
        .brownout_detect(brownout_detect), .external_reset_pin_n(external_reset_pin_n),
        .oscillator_input(oscillator_input), .powerup_timer_tick(powerup_timer_tick),
        .sleep_wakeup(sleep_wakeup), .watchdog_reset(watchdog_reset), .cfg(cfg),
        .wdt_flags(wdt_flags), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .internal_reset(internal_reset),
        .reset_cause(reset_cause), .brownout_flag_n(brownout_flag_n),
        .poweron_flag_n(poweron_flag_n), .powerup_timer_active(powerup_timer_active),
        .osc_startup_active(osc_startup_active)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [3:0] seen, input logic [3:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic span(input int val, input int lo, input int hi);
        check({3'h0, val >= lo && val <= hi}, 4'h1, "time-out length");
    endtask
    task automatic wr(input logic a, input logic [1:0] val);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= val;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic a);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic chk_status();
        rd(1'b0);
        check(d, {(por_n != 0) ? 2'(wdt_flags) : 2'h3, por_n[0], bor_n[0]}, "status");
    endtask
    task automatic run_seq();
        pw = 0;
        os = 0;
        for (int n = 0; n < 5000 && internal_reset !== 1'b0; n++) begin
            @(posedge mclk);
            #1 pw += int'(powerup_timer_active);
            os += int'(osc_startup_active);
        end
        check({3'h0, internal_reset}, 4'h0, "reset release");
    endtask
    task automatic power_up(input logic [1:0] m, input logic dis_n, input logic pin);
        @(posedge mclk);
        rst <= 1'b1;
        poweron_pulse <= 1'b1;
        external_reset_pin_n <= pin;
        cfg <= '{m, dis_n, 1'b1};
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        repeat (6) @(posedge mclk);
        #1 check({2'h0, reset_cause}, {2'h0, RTS_CAUSE_POWERON}, "cause");
        @(posedge mclk);
        poweron_pulse <= 1'b0;
        por_n = 0;
        bor_n = 0;
    endtask
    task automatic dip(input int n);
        @(posedge mclk);
        brownout_detect <= 1'b1;
        repeat (n) @(posedge mclk);
        brownout_detect <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #1_000_000;
        n_fail++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(85676));
        for (int m = 0; m < 8; m++) begin
            power_up(m[2:1], m[0], 1'b1);
            run_seq();
            if (m[0]) span(pw, 0, 0);
            else span(pw, (PW - 1) * TK + 1, PW * TK + 2);
            if (m[2:1] == OSC_RC) span(os, 0, 0);
            else span(os, 2 * STARTUP_PERIODS - 1, 2 * STARTUP_PERIODS + 2);
            chk_status();
        end
        // Pin held low across the whole sequence: the start-up count expires under it.
        power_up(OSC_STANDARD, 1'b1, 1'b0);
        repeat (2 * STARTUP_PERIODS + 20) @(posedge mclk);
        #1 check({internal_reset, 2'h0, osc_startup_active}, 4'h8, "pin held");
        @(posedge mclk);
        external_reset_pin_n <= 1'b1;
        run_seq();
        span(pw + os, 0, 0);
        wr(1'b1, 2'h0);
        rd(1'b1);
        check(d, 4'h0, "unmapped read");
        repeat (4) begin
            v = 2'($urandom);
            wr(1'b0, v);
            por_n = int'(v[1]);
            bor_n = int'(v[0]);
            chk_status();
        end
        wr(1'b0, 2'h3);
        por_n = 1;
        bor_n = 1;
        dip(1 + $urandom % 2);
        repeat (6) @(posedge mclk);
        #1 check({3'h0, internal_reset}, 4'h0, "short dip");
        chk_status();
        dip(20);
        #1 check({internal_reset, 1'b0, reset_cause}, {2'h2, RTS_CAUSE_BROWNOUT}, "dip");
        repeat (12) @(posedge mclk);
        dip(20);
        bor_n = 0;
        run_seq();
        span(pw, (PW - 1) * TK + 1, PW * TK + 2);
        chk_status();
        @(posedge mclk);
        external_reset_pin_n <= 1'b0;
        repeat (2) @(posedge mclk);
        external_reset_pin_n <= 1'b1;
        repeat (6) @(posedge mclk);
        #1 check({3'h0, internal_reset}, 4'h0, "pin glitch");
        @(posedge mclk);
        external_reset_pin_n <= 1'b0;
        watchdog_reset <= 1'b1;
        repeat (12) @(posedge mclk);
        #1 check({internal_reset, 1'b0, reset_cause}, {2'h2, RTS_CAUSE_OTHER}, "wdt");
        @(posedge mclk);
        external_reset_pin_n <= 1'b1;
        watchdog_reset <= 1'b0;
        run_seq();
        chk_status();
        @(posedge mclk);
        sleep_wakeup <= 1'b1;
        @(posedge mclk);
        sleep_wakeup <= 1'b0;
        @(posedge mclk);
        #1 check({3'h0, internal_reset}, 4'h1, "wake hold");
        run_seq();
        span(os, 2 * STARTUP_PERIODS - 3, 2 * STARTUP_PERIODS + 2);
        end_of_test();
    end
endmodule
bind rts_sequencer rts_checker i_rts_checker (
    .mclk(mclk), .rst(rst), .clk_en(clk_en), .poweron_pulse(poweron_pulse),
    .brownout_detect(brownout_detect), .external_reset_pin_n(external_reset_pin_n),
    .cfg(cfg), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .internal_reset(internal_reset), .brownout_flag_n(brownout_flag_n),
    .poweron_flag_n(poweron_flag_n), .powerup_timer_active(powerup_timer_active),
    .osc_startup_active(osc_startup_active)
);
`default_nettype wire
